// *** core/spbc_pkg.sv ***
package spbc_pkg;

  localparam int SPBC_SEGS = 4;
  localparam int SPBC_DW = 128;
  localparam int SPBC_BYTES = 16;

  // Transmit segment store and backpressure figures.
  localparam int SPBC_TXQ_DEPTH = 64;
  localparam int SPBC_TXQ_AW = 6;
  localparam logic [3:0] SPBC_OVF_THRESHOLD = 4'hb;
  localparam logic [SPBC_TXQ_AW:0] SPBC_RDY_FREE = 7'h2c;

  localparam logic [15:0] SPBC_MIN_FRAME = 16'h0040;
  localparam logic [SPBC_DW-1:0] SPBC_ERR_WORD = {16{8'hfe}};

  // Register map, byte addresses.
  localparam logic [11:0] SPBC_REG_CTRL = 12'h000;
  localparam logic [11:0] SPBC_REG_STATUS = 12'h004;
  localparam logic [11:0] SPBC_REG_TX_SMALL = 12'h008;
  localparam logic [11:0] SPBC_REG_RX_ERR = 12'h00c;
  localparam logic [14:0] SPBC_LEN_LIMIT_RST = 15'h2580;
  localparam int SPBC_ST_OVF = 0;
  localparam int SPBC_ST_RDY = 1;
  localparam int SPBC_ST_LINE_RDY = 2;

  typedef struct packed {
    logic [SPBC_DW-1:0] data;
    logic ena;
    logic sop;
    logic eop;
    logic err;
    logic [3:0] mty;
  } spbc_seg_t;

  typedef struct packed {
    logic [SPBC_DW-1:0] data;
    logic vld;
    logic sop;
    logic eop;
    logic [3:0] mty;
    logic fcs_bad;
    logic code_bad;
  } spbc_line_t;

endpackage

// *** core/spbc_rx_lane.sv ***
`timescale 1ns/1ps
`default_nettype none

module spbc_rx_lane
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic clear,
  // Data
  input wire spbc_pkg::spbc_seg_t seg_in,
  output spbc_pkg::spbc_seg_t seg_out
);

  import spbc_pkg::*;

  spbc_seg_t seg_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seg_r <= '0;
    end else if (load) begin
      seg_r <= seg_in;
    end else if (clear) begin
      seg_r <= '0;
    end
  end

  assign seg_out = seg_r;

endmodule

`default_nettype wire

// *** core/spbc_top.sv ***
// What this block does
// [R1] All bus signals launch and sample on the rising clock edge; receive data whenever enabled.
// [R2] User may write freely while transmit ready is high; ready and overflow are shared.
// [R3] After ready falls user may do at most eight more write cycles.
// [R4] Core raises transmit overflow when write cycles without ready reach eleven.
// [R5] One write right after ready falls is fine; better to wait for ready.
// [R6] A cycle that pauses for backpressure has all four transmit enables low.
// [R7] No idle cycles inside a packet while ready is high; that underruns the line.
// [R8] Packets are written whole; only low ready may interrupt them.
// [R9] Segments 0 to 3; segment 0 active whenever data moves, first bit at its top.
// [R10] First packet byte sits in bits 127 to 120 of a segment, then downward.
// [R11] Active transmit segments are contiguous from segment 0 upward.
// [R12] Segments after an end marker may be idle; a start may follow directly.
// [R13] No two start markers in one bus cycle.
// [R14] Every packet closes with an end marker before the next start.
// [R15] Empty count is 0 for 16 valid bytes, else number of invalid trailing lanes.
// [R16] Receive segments are full except the end segment, whose empty count matches transmit.
// [R17] Receive error on last transfer for bad FCS, bad code, or length out of range.
// [R18] User must take receive data every enabled cycle; no receive backpressure.
// [R19] Receive side accumulates before forwarding, so all-idle receive cycles occur.
// [R20] Transmit packets under 64 bytes raise the undersize statistic.
// [R21] After overflow the user stops writing and resets the core.
// [R22] Receive start and end come in one cycle for packets within the bus width.
// [R23] A transmit end marked in error has its last word replaced by the error code.
// [R24] Receive error forces empty bits 2:0 to zero; transmit ignores them on error.
// [R25] Transmit overflow stays high until reset.
`timescale 1ns/1ps
`default_nettype none

module spbc_top
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB register slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Transmit segmented packet bus
  input wire spbc_pkg::spbc_seg_t [spbc_pkg::SPBC_SEGS-1:0] TX_SEG,
  output logic TX_RDY,
  output logic TX_OVF,
  output logic TX_STAT_SMALL,
  // Receive segmented packet bus
  output spbc_pkg::spbc_seg_t [spbc_pkg::SPBC_SEGS-1:0] RX_SEG,
  // Line side, one segment per cycle each way
  input wire logic LINE_TX_READY,
  output spbc_pkg::spbc_line_t LINE_TX,
  input wire spbc_pkg::spbc_line_t LINE_RX
);

  import spbc_pkg::*;

  // Register state.
  logic [14:0] len_limit_r;
  logic [31:0] small_cnt_r;
  logic [31:0] rx_err_cnt_r;

  // Transmit state.
  spbc_seg_t txq_r [SPBC_TXQ_DEPTH];
  logic [SPBC_TXQ_AW-1:0] wr_ptr_r;
  logic [SPBC_TXQ_AW-1:0] rd_ptr_r;
  logic [SPBC_TXQ_AW:0] fill_r;
  logic [3:0] late_cnt_r;
  logic [15:0] tx_len_r;
  logic [15:0] tx_len_nxt;
  logic [1:0] small_nxt;
  logic [2:0] wr_num;
  logic wr_cycle;
  logic rd_go;
  logic [SPBC_TXQ_AW:0] free_nxt;

  // Line ready synchroniser.
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic line_rdy_r;

  // Receive state.
  spbc_seg_t lane_in;
  spbc_seg_t [SPBC_SEGS-1:0] lane_q;
  logic [1:0] lane_idx_r;
  logic flush_r;
  logic [15:0] rx_len_r;
  logic [15:0] rx_len_sum;
  logic code_bad_r;
  logic rx_bad;

  // APB access phase.
  logic apb_acc;
  logic apb_hit;
  assign apb_acc = PSEL && PENABLE && PREADY;
  assign apb_hit = (PADDR == SPBC_REG_CTRL) || (PADDR == SPBC_REG_STATUS) ||
                   (PADDR == SPBC_REG_TX_SMALL) || (PADDR == SPBC_REG_RX_ERR);

  // One wait state keeps read data and the answer both registered.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !PREADY) begin
      PSLVERR <= !apb_hit;
      PRDATA <= 32'h0000_0000;
      if (!PWRITE) begin
        unique case (PADDR)
          SPBC_REG_CTRL: PRDATA <= {17'h00000, len_limit_r};
          SPBC_REG_STATUS: PRDATA <= {29'h0000_0000, line_rdy_r, TX_RDY, TX_OVF};
          SPBC_REG_TX_SMALL: PRDATA <= small_cnt_r;
          SPBC_REG_RX_ERR: PRDATA <= rx_err_cnt_r;
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end else begin
      PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      len_limit_r <= SPBC_LEN_LIMIT_RST;
    end else if (apb_acc && PWRITE && PADDR == SPBC_REG_CTRL) begin
      len_limit_r <= PWDATA[14:0];
    end
  end

  // Line ready arrives from another domain; a change counts once two stages agree.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      line_rdy_r <= 1'b0;
    end else begin
      sync1_r <= LINE_TX_READY;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        line_rdy_r <= sync3_r;
      end
    end
  end

  // Write accounting: segments are contiguous from 0, so the count is the prefix.
  always_comb begin
    wr_num = 3'h0;
    for (int i = 0; i < SPBC_SEGS; i++) begin
      if (TX_SEG[i].ena) begin
        wr_num = 3'(i + 1); // [R11]
      end
    end
  end

  assign wr_cycle = TX_SEG[0].ena && !TX_OVF; // [R9]
  assign rd_go = line_rdy_r && (fill_r != '0);

  // Undersize detection runs across segments, since a packet may end and start in one cycle.
  always_comb begin
    tx_len_nxt = tx_len_r;
    small_nxt = 2'h0;
    for (int i = 0; i < SPBC_SEGS; i++) begin
      if (wr_cycle && TX_SEG[i].ena) begin
        if (TX_SEG[i].sop) begin
          tx_len_nxt = 16'h0000; // [R12]
        end
        if (TX_SEG[i].eop) begin
          tx_len_nxt = tx_len_nxt + 16'(SPBC_BYTES) -
                       {12'h000, TX_SEG[i].mty[3], TX_SEG[i].err ? 3'h0 : TX_SEG[i].mty[2:0]}; // [R15] [R24]
          if (tx_len_nxt < SPBC_MIN_FRAME) begin
            small_nxt = small_nxt + 2'h1; // [R20]
          end
          tx_len_nxt = 16'h0000;
        end else begin
          tx_len_nxt = tx_len_nxt + 16'(SPBC_BYTES);
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_len_r <= 16'h0000;
      TX_STAT_SMALL <= 1'b0;
      small_cnt_r <= 32'h0000_0000;
    end else begin
      tx_len_r <= tx_len_nxt;
      TX_STAT_SMALL <= small_nxt != 2'h0; // [R20]
      small_cnt_r <= small_cnt_r + {30'h0000_0000, small_nxt};
    end
  end

  // Segment store; an errored end carries the error word in place of its data.
  always_ff @(posedge CLK) begin
    for (int i = 0; i < SPBC_SEGS; i++) begin
      if (wr_cycle && TX_SEG[i].ena && (fill_r + 7'(i)) < 7'(SPBC_TXQ_DEPTH)) begin
        txq_r[wr_ptr_r + SPBC_TXQ_AW'(i)] <= TX_SEG[i];
        if (TX_SEG[i].eop && TX_SEG[i].err) begin
          txq_r[wr_ptr_r + SPBC_TXQ_AW'(i)].data <= SPBC_ERR_WORD; // [R23]
          txq_r[wr_ptr_r + SPBC_TXQ_AW'(i)].mty <= {TX_SEG[i].mty[3], 3'h0}; // [R24]
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fill_r <= '0;
    end else begin
      if (wr_cycle) begin
        wr_ptr_r <= wr_ptr_r + SPBC_TXQ_AW'(wr_num);
      end
      if (rd_go) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      fill_r <= fill_r + (wr_cycle ? 7'(wr_num) : 7'h00) - (rd_go ? 7'h01 : 7'h00);
    end
  end

  assign free_nxt = 7'(SPBC_TXQ_DEPTH) - (fill_r + (wr_cycle ? 7'(wr_num) : 7'h00) -
                    (rd_go ? 7'h01 : 7'h00));

  // Ready leaves room for the ten late write cycles a user could make before overflow.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_RDY <= 1'b0;
    end else begin
      TX_RDY <= !TX_OVF && (free_nxt >= SPBC_RDY_FREE); // [R2]
    end
  end

  // Late write cycles are counted against the ready level the user saw.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      late_cnt_r <= 4'h0;
      TX_OVF <= 1'b0; // [R25]
    end else begin
      if (TX_RDY) begin
        late_cnt_r <= 4'h0;
      end else if (TX_SEG[0].ena && late_cnt_r != SPBC_OVF_THRESHOLD) begin
        late_cnt_r <= late_cnt_r + 4'h1; // [R3]
      end
      if (!TX_RDY && TX_SEG[0].ena && late_cnt_r + 4'h1 >= SPBC_OVF_THRESHOLD) begin
        TX_OVF <= 1'b1; // [R4]
      end else if (wr_cycle && (fill_r + 7'(wr_num)) > 7'(SPBC_TXQ_DEPTH)) begin
        TX_OVF <= 1'b1; // [R4]
      end
    end
  end
  // The flag is never cleared here; only a reset recovers the store.

  // Line transmit output, one segment per cycle while the line is ready.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LINE_TX <= '0;
    end else begin
      LINE_TX.vld <= rd_go; // [R1]
      if (rd_go) begin
        LINE_TX.data <= txq_r[rd_ptr_r].data; // [R10]
        LINE_TX.sop <= txq_r[rd_ptr_r].sop;
        LINE_TX.eop <= txq_r[rd_ptr_r].eop;
        LINE_TX.mty <= txq_r[rd_ptr_r].eop ? txq_r[rd_ptr_r].mty : 4'h0;
        LINE_TX.fcs_bad <= txq_r[rd_ptr_r].eop && txq_r[rd_ptr_r].err;
        LINE_TX.code_bad <= 1'b0;
      end
    end
  end

  // Receive length and error checking on each incoming segment.
  assign rx_len_sum = (LINE_RX.sop ? 16'h0000 : rx_len_r) + 16'(SPBC_BYTES) -
                      (LINE_RX.eop ? {12'h000, LINE_RX.mty} : 16'h0000);
  assign rx_bad = LINE_RX.fcs_bad || LINE_RX.code_bad || code_bad_r ||
                  rx_len_sum < SPBC_MIN_FRAME || rx_len_sum > {1'b0, len_limit_r}; // [R17]

  always_comb begin
    lane_in = '0;
    lane_in.data = LINE_RX.data; // [R10]
    lane_in.ena = 1'b1;
    lane_in.sop = LINE_RX.sop;
    lane_in.eop = LINE_RX.eop;
    if (LINE_RX.eop) begin
      lane_in.err = rx_bad; // [R17]
      lane_in.mty = rx_bad ? {LINE_RX.mty[3], 3'h0} : LINE_RX.mty; // [R24]
    end else begin
      lane_in.mty = 4'h0; // [R16]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_len_r <= 16'h0000;
      code_bad_r <= 1'b0;
      rx_err_cnt_r <= 32'h0000_0000;
    end else if (LINE_RX.vld) begin
      rx_len_r <= (rx_len_sum[15] ? 16'hffff : rx_len_sum);
      code_bad_r <= !LINE_RX.eop && (LINE_RX.code_bad || (code_bad_r && !LINE_RX.sop));
      if (LINE_RX.eop && rx_bad) begin
        rx_err_cnt_r <= rx_err_cnt_r + 32'h0000_0001;
      end
    end
  end

  // Segments gather into a group; the group goes out after segment 3 or an end marker.
  // Flushing at each end keeps the next packet on segment 0 and short frames in one cycle.
  for (genvar g = 0; g < SPBC_SEGS; g++) begin : g_lane
    spbc_rx_lane u_lane (
      .clk(CLK),
      .rst_n(RST_N),
      .load(LINE_RX.vld && lane_idx_r == 2'(g)),
      .clear(flush_r),
      .seg_in(lane_in),
      .seg_out(lane_q[g])
    );
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lane_idx_r <= 2'h0;
      flush_r <= 1'b0;
    end else begin
      flush_r <= LINE_RX.vld && (LINE_RX.eop || lane_idx_r == 2'h3); // [R19]
      if (LINE_RX.vld) begin
        lane_idx_r <= LINE_RX.eop ? 2'h0 : lane_idx_r + 2'h1; // [R22]
      end
    end
  end

  // The user must take every enabled cycle; nothing here waits for it.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RX_SEG <= '0;
    end else if (flush_r) begin
      RX_SEG <= lane_q; // [R18]
    end else begin
      for (int i = 0; i < SPBC_SEGS; i++) begin
        RX_SEG[i].ena <= 1'b0; // [R19]
      end
    end
  end

endmodule

`default_nettype wire

// *** testbench/spbc_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none

module spbc_top_props
  import spbc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Segmented packet bus
  input wire spbc_seg_t [SPBC_SEGS-1:0] TX_SEG,
  input wire logic TX_RDY,
  input wire logic TX_OVF,
  input wire logic TX_STAT_SMALL,
  input wire spbc_seg_t [SPBC_SEGS-1:0] RX_SEG
);
  logic [3:0] rx_en;
  logic tx_eop;
  logic rx_mty_ok;

  always_comb begin
    tx_eop = 1'b0;
    rx_mty_ok = 1'b1;
    for (int i = 0; i < SPBC_SEGS; i++) begin
      rx_en[i] = RX_SEG[i].ena;
      tx_eop = tx_eop | (TX_SEG[i].ena & TX_SEG[i].eop);
      if (RX_SEG[i].ena && RX_SEG[i].err && RX_SEG[i].mty[2:0] != 3'h0) begin
        rx_mty_ok = 1'b0;
      end
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  AST_OVF_STICKY: assert property (TX_OVF |=> TX_OVF) else $error("overflow flag dropped");
  AST_OVF_CAUSE: assert property ($rose(TX_OVF) |-> $past(TX_SEG[0].ena) && !$past(TX_RDY)) else $error("overflow without late write");
  AST_SMALL_CAUSE: assert property (TX_STAT_SMALL |-> $past(tx_eop)) else $error("undersize without end marker");
  AST_RX_CONTIG: assert property (rx_en != 4'h0 |-> rx_en inside {4'h1, 4'h3, 4'h7, 4'hf}) else $error("receive segments not packed");
  AST_RX_ERR_MTY: assert property (rx_mty_ok) else $error("errored receive empty count low bits set");
  AST_APB_WAIT: assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY) else $error("ready not after one wait");
  AST_APB_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  AST_APB_ERR: assert property (PSLVERR |-> PREADY && PSEL) else $error("slave error outside access");
endmodule

bind spbc_top spbc_top_props u_props (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_SEG(TX_SEG), .TX_RDY(TX_RDY), .TX_OVF(TX_OVF),
  .TX_STAT_SMALL(TX_STAT_SMALL), .RX_SEG(RX_SEG));

`default_nettype wire

// *** testbench/spbc_user_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module spbc_user_model
  import spbc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command from the bench
  input wire logic go,
  input wire logic force_wr,
  input wire logic [2:0] nseg,
  input wire logic [3:0] mty,
  input wire logic err,
  input wire logic [7:0] base,
  // Segmented packet bus
  input wire logic rdy,
  output spbc_seg_t [SPBC_SEGS-1:0] seg
);
  // Each packet fits one cycle, so no idle cycle can fall inside it.
  always_ff @(posedge clk) begin
    for (int i = 0; i < SPBC_SEGS; i++) begin
      seg[i] <= '0;
      seg[i].data <= ~seg[i].data;
      if (rst_n && go && (rdy || force_wr) && i < int'(nseg)) begin
        seg[i].data <= {16{base ^ 8'(i)}};
        seg[i].ena <= 1'b1;
        seg[i].sop <= (i == 0);
        seg[i].eop <= (i == int'(nseg) - 1);
        seg[i].err <= err && (i == int'(nseg) - 1);
        seg[i].mty <= (i == int'(nseg) - 1) ? mty : 4'h0;
      end
    end
  end
endmodule

`default_nettype wire

// *** testbench/spbc_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module spbc_top_tb;
  import spbc_pkg::*;
  logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, LINE_TX_READY = 1;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, q;
  logic PREADY, PSLVERR, TX_RDY, TX_OVF, TX_STAT_SMALL, e;
  spbc_seg_t [SPBC_SEGS-1:0] TX_SEG, RX_SEG;
  spbc_line_t LINE_TX, LINE_RX = '0;
  logic go = 0, force_wr = 0, err = 0;
  logic [2:0] nseg = 3'h1;
  logic [3:0] mty = '0;
  logic [7:0] base = '0;
  int failures = 0, comparisons = 0, seed = 32'h8ae7, k, n, t = 0, small_n = 0, rx_bad_n = 0;

  always #10 CLK = ~CLK;

  spbc_top uut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_SEG(TX_SEG), .TX_RDY(TX_RDY), .TX_OVF(TX_OVF), .TX_STAT_SMALL(TX_STAT_SMALL),
    .RX_SEG(RX_SEG), .LINE_TX_READY(LINE_TX_READY), .LINE_TX(LINE_TX), .LINE_RX(LINE_RX));
  spbc_user_model model (.clk(CLK), .rst_n(RST_N), .go(go), .force_wr(force_wr), .nseg(nseg),
    .mty(mty), .err(err), .base(base), .rdy(TX_RDY), .seg(TX_SEG));

  task automatic summarize;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [139:0] ex, input logic [139:0] got);
    comparisons++;
    if (ex !== got) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Writes take effect at the edge where ready is seen; read data is captured one edge earlier.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int c;
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    c = 0;
    do begin
      @(posedge CLK);
      c++;
    end while (PREADY !== 1'b1 && c < 20);
    if (c == 20) begin
      failures++;
      summarize();
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLK);
  endtask

  task automatic tx_pkt(input logic [2:0] ns, input logic [3:0] my, input logic er);
    int j;
    logic sm;
    logic xs;
    logic [SPBC_DW-1:0] d;
    j = 0;
    sm = 0;
    base <= 8'($random(seed));
    nseg <= ns;
    mty <= my;
    err <= er;
    go <= 1;
    @(posedge CLK);
    go <= 0;
    repeat (14) begin
      @(posedge CLK);
      sm |= TX_STAT_SMALL;
      if (LINE_TX.vld === 1'b1) begin
        d = (er && j == ns - 1) ? SPBC_ERR_WORD : {16{base ^ 8'(j)}};
        chk("line_tx", {d, j == 0, j == ns - 1, j == ns - 1 ? {my[3], er ? 3'h0 : my[2:0]} : 4'h0, er && j == ns - 1},
          {LINE_TX.data, LINE_TX.sop, LINE_TX.eop, LINE_TX.mty, LINE_TX.fcs_bad});
        j++;
      end
    end
    chk("line_tx count", ns, j);
    // An errored end ignores the low empty bits, so its length counts them as zero.
    xs = ns * 16 - (er ? my & 4'h8 : my) < 64;
    small_n += int'(xs);
    chk("tx_small", xs, sm);
  endtask

  task automatic rx_pkt(input int ns, input logic [3:0] my, input logic fb, input logic cb, input int lim);
    logic [7:0] b;
    logic bad;
    int j;
    b = 8'($random(seed));
    bad = fb || cb || ns * 16 - my < 64 || ns * 16 - my > lim;
    rx_bad_n += int'(bad);
    for (j = 0; j < ns; j++) begin
      LINE_RX <= '{data: {16{b + 8'(j)}}, vld: 1'b1, sop: j == 0, eop: j == ns - 1,
        mty: j == ns - 1 ? my : 4'h0, fcs_bad: fb && j == ns - 1, code_bad: cb && j == 0};
      @(posedge CLK);
    end
    LINE_RX <= '{data: ~LINE_RX.data, default: '0};
    j = 0;
    while (RX_SEG[0].ena !== 1'b1 && j < 10) begin
      @(posedge CLK);
      j++;
    end
    for (j = 0; j < SPBC_SEGS; j++) begin
      chk("rx_seg", {j < ns, j < ns ? {16{b + 8'(j)}} : 128'h0, j == 0, j == ns - 1, bad && j == ns - 1,
        j == ns - 1 ? {my[3], bad ? 3'h0 : my[2:0]} : 4'h0}, {RX_SEG[j].ena, j < ns ? RX_SEG[j].data : 128'h0,
        j < ns && RX_SEG[j].sop, j < ns && RX_SEG[j].eop, j == ns - 1 && RX_SEG[j].err,
        j == ns - 1 ? RX_SEG[j].mty : 4'h0});
    end
  endtask

  initial begin
    repeat (10) @(posedge CLK);
    RST_N <= 1;
    repeat (2) @(posedge CLK);
    apb(0, SPBC_REG_CTRL, 0);
    chk("ctrl reset", {17'h0, SPBC_LEN_LIMIT_RST}, q);
    apb(1, SPBC_REG_CTRL, 32'h30);
    apb(0, SPBC_REG_CTRL, 0);
    chk("ctrl", 32'h30, q);
    apb(0, 12'h010, 0);
    chk("unmapped", 1, e);
    rx_pkt(4, 0, 0, 0, 48);
    apb(1, SPBC_REG_CTRL, 32'h2580);
    rx_pkt(4, 0, 0, 0, 9600);
    rx_pkt(4, 5, 1, 0, 9600);
    rx_pkt(4, 0, 0, 1, 9600);
    rx_pkt(1, 2, 0, 0, 9600);
    rx_pkt(3, 0, 0, 0, 9600);
    apb(0, SPBC_REG_RX_ERR, 0);
    chk("rx_err count", rx_bad_n, q);
    tx_pkt(4, 0, 0);
    tx_pkt(4, 1, 0);
    tx_pkt(3, 6, 1);
    repeat (6) tx_pkt(3'(1 + $unsigned($random(seed)) % 4), 4'($random(seed)), 1'($random(seed)));
    apb(0, SPBC_REG_TX_SMALL, 0);
    chk("tx_small count", small_n, q);
    LINE_TX_READY <= 0;
    nseg <= 4;
    mty <= 0;
    err <= 0;
    force_wr <= 1;
    go <= 1;
    k = 0;
    n = 0;
    // Bounded: if ready never falls the late-write count stays short and is reported.
    while ((k < 7 || (k < 10 && n > 0)) && t < 60) begin
      @(posedge CLK);
      t++;
      if (TX_SEG[0].ena === 1'b1 && TX_RDY === 1'b0) k++;
      if (k == 7 && n == 0) begin
        go <= 0;
        repeat (4) @(posedge CLK);
        chk("ovf after eight", 0, TX_OVF);
        go <= 1;
        n = 1;
      end
    end
    chk("late writes", 10, k);
    go <= 0;
    repeat (3) @(posedge CLK);
    chk("ovf", 1, TX_OVF);
    repeat (5) @(posedge CLK);
    apb(0, SPBC_REG_STATUS, 0);
    chk("ovf status", 1, q[SPBC_ST_OVF]);
    chk("rdy status", 0, q[SPBC_ST_RDY]);
    chk("line status", 0, q[SPBC_ST_LINE_RDY]);
    RST_N <= 0;
    force_wr <= 0;
    LINE_TX_READY <= 1;
    repeat (2) @(posedge CLK);
    RST_N <= 1;
    repeat (2) @(posedge CLK);
    chk("ovf cleared", 0, TX_OVF);
    chk("rdy after reset", 1, TX_RDY);
    summarize();
  end
endmodule

`default_nettype wire
